// [sdcm_pkg.sv]
// package of constants and carriers for the sdram command and mode logic
package sdcm_pkg;
   // ------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int BANK_W = 2;
   localparam int DATA_W = 32;
   localparam int MASK_W = 4;
   localparam int COL_W  = 8;
   localparam int NBANK  = 4;
   localparam int MODE_W = 14;
   // ------------------------------------------------------------
   // mode register fields
   // ------------------------------------------------------------
   localparam int BL_LSB = 0;
   localparam int BL_MSB = 2;
   localparam int BT_BIT = 3;
   localparam int RL_LSB = 4;
   localparam int RL_MSB = 6;
   localparam int OP_LSB = 7;
   localparam int OP_MSB = 13;
   localparam logic [MODE_W-1:0] MODE_RST       = 14'h0022;
   localparam logic [2:0]        BL_CODE_1      = 3'h0;
   localparam logic [2:0]        BL_CODE_2      = 3'h1;
   localparam logic [2:0]        BL_CODE_4      = 3'h2;
   localparam logic [2:0]        BL_CODE_8      = 3'h3;
   localparam logic [2:0]        BL_CODE_PAGE   = 3'h7;
   localparam logic [2:0]        RL_CODE_2      = 3'h2;
   localparam logic [2:0]        RL_CODE_3      = 3'h3;
   localparam logic [6:0]        OP_BURST_WRITE = 7'h00;
   localparam logic [6:0]        OP_SINGLE_WR   = 7'h04;
   localparam int                PRE_ALL_BIT    = 10;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int ROW_CYCLE_NS  = 60;
   localparam int ROW_CYCLE_CYC = (ROW_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MASK_RD_LAT   = 2;
   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic              chip_select_n;
      logic              row_strobe_n;
      logic              column_strobe_n;
      logic              write_strobe_n;
      logic              clk_gate;
      logic [BANK_W-1:0] bank_select;
      logic [ADDR_W-1:0] addr;
   } sdcm_cmd_s;
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [MASK_W-1:0] mask;
   } sdcm_beat_s;
endpackage

// [sdcm_burst_addr.sv]
// burst column generator: sequential, interleave and full page
`timescale 1ns/1ps
`default_nettype none
module sdcm_burst_addr import sdcm_pkg::*; #(
   parameter int CW = COL_W
) (
   // start column, beat index, mode
   input  wire logic [CW-1:0] start_col,
   input  wire logic [CW-1:0] beat,
   input  wire logic [2:0]    bl_code,
   input  wire logic          interleave,
   // column for this beat
   output logic [CW-1:0]      col
);
   logic [CW-1:0] blk;
   always_comb begin
      case (bl_code)
         BL_CODE_2: blk = CW'(1);
         BL_CODE_4: blk = CW'(3);
         BL_CODE_8: blk = CW'(7);
         BL_CODE_PAGE: blk = '1;
         default: blk = '0;
      endcase
      if (interleave && bl_code != BL_CODE_PAGE) begin
         col = (start_col & ~blk) | ((start_col ^ beat) & blk);
      end else begin
         col = (start_col & ~blk) | ((start_col + beat) & blk);
      end
   end
endmodule // sdcm_burst_addr
`default_nettype wire

// [sdcm_skid.sv]
// two-entry buffer on the read data path
`timescale 1ns/1ps
`default_nettype none
module sdcm_skid import sdcm_pkg::*; #(
   parameter int W = DATA_W + MASK_W
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // fill side
   input  wire logic         in_valid,
   output logic             in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic             out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   typedef struct packed {
      logic [1:0][W-1:0] mem;
      logic              wp;
      logic              rp;
      logic [1:0]        cnt;
   } sdcm_skid_s;
   sdcm_skid_s s_r, s_nxt;
   logic push, pop;
   always_comb begin
      s_nxt = s_r;
      in_ready = (s_r.cnt != 2'h2);
      out_valid = (s_r.cnt != 2'h0);
      out_data = s_r.mem[s_r.rp];
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      if (push) begin
         s_nxt.mem[s_r.wp] = in_data;
         s_nxt.wp = ~s_r.wp;
      end
      if (pop) begin
         s_nxt.rp = ~s_r.rp;
      end
      s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule // sdcm_skid
`default_nettype wire

// [sdcm_core.sv]
// sdram command decoder, mode register, burst engine and refresh state
// Summary of operation
// - row, column and write strobes low load mode from address and bank
// - burst length codes 0..3 give 1,2,4,8; code 7 full page
// - mode bit 3 picks sequential or interleave order
// - read latency codes 2 and 3 give two or three clocks
// - operation mode zero bursts writes; bit 9 alone gives single writes
// - activate opens addressed row in selected bank
// - column command after activation; write strobe picks read or write
// - first column from command, rest generated inside aligned burst block
// - interleave XORs beat count; sequential increments with wrap
// - full page wraps at page end and runs until another command
// - a new column command at any clock restarts a full burst
// - refresh address comes from an internal counter, needs no bank
// - auto refresh on row and column strobes low, self-precharges afterwards
// - self refresh entry with clock gate low; raising it exits
// - read mask floats outputs two clocks later; write mask is immediate
// - power-down entry when gate low with banks idle; three clocks each way
// - chip select high masks every command
// - precharge select bit requests auto precharge or precharge of all banks
`timescale 1ns/1ps
`default_nettype none
module sdcm_core import sdcm_pkg::*; #(
   parameter int ROWS_PER_BANK = 4096
) (
   // clock and reset
   input  wire logic                SYS_CLK,
   input  wire logic                RST,
   // command pins
   input  wire logic                CHIP_SELECT_N,
   input  wire logic                ROW_STROBE_N,
   input  wire logic                COLUMN_STROBE_N,
   input  wire logic                WRITE_STROBE_N,
   input  wire logic                CLK_GATE,
   input  wire logic [BANK_W-1:0]   BANK_SELECT,
   input  wire logic [ADDR_W-1:0]   ADDR,
   input  wire logic [MASK_W-1:0]   BYTE_MASK,
   // data pins
   input  wire logic [DATA_W-1:0]   DQ_IN,
   output logic [DATA_W-1:0]        DQ_OUT,
   output logic [MASK_W-1:0]        DQ_OE,
   // array port
   output logic                     ARR_WR,
   output logic [BANK_W-1:0]        ARR_BANK,
   output logic [ADDR_W-1:0]        ARR_ROW,
   output logic [COL_W-1:0]         ARR_COL,
   output logic [DATA_W-1:0]        ARR_WDATA,
   output logic [MASK_W-1:0]        ARR_WMASK,
   input  wire logic [DATA_W-1:0]   ARR_RDATA,
   // status
   output logic [MODE_W-1:0]        MODE_VALUE,
   output logic [NBANK-1:0]         BANK_OPEN,
   output logic                     SELF_REFRESH,
   output logic                     POWER_DOWN,
   output logic                     REFRESH_PULSE,
   output logic [ADDR_W-1:0]        REFRESH_ROW,
   output logic                     READ_STALL
);
   // ------------------------------------------------------------
   // types and state
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_BURST = 4'h2,
      ST_SELF = 4'h4,
      ST_PDOWN = 4'h8
   } sdcm_st_e;
   localparam int RL_PIPE = 3;
   typedef struct packed {
      sdcm_st_e                  st;
      logic [MODE_W-1:0]         mode;
      logic [NBANK-1:0]          open;
      logic [NBANK-1:0][ADDR_W-1:0] row;
      logic [BANK_W-1:0]         bbank;
      logic [COL_W-1:0]          bcol;
      logic [COL_W-1:0]          beat;
      logic [COL_W-1:0]          left;
      logic                      bwr;
      logic                      bap;
      logic [ADDR_W-1:0]         rcnt;
      logic                      rpulse;
      logic [RL_PIPE-1:0]        rdv;
      logic [RL_PIPE-2:0][DATA_W-1:0] rdp;
      logic [MASK_W-1:0]         mask_d1;
      logic [MASK_W-1:0]         oe;
      logic [DATA_W-1:0]         dout;
      logic                      awr;
      logic [BANK_W-1:0]         abank;
      logic [ADDR_W-1:0]         arow;
      logic [COL_W-1:0]          acol;
      logic [DATA_W-1:0]         awdata;
      logic [MASK_W-1:0]         awmask;
      logic [2:0]                gate_sync;
      logic                      gate_q;
   } sdcm_core_s;
   sdcm_core_s s_r, s_nxt;
   sdcm_cmd_s  cmd;
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [COL_W-1:0] burst_len(input logic [2:0] code);
      case (code)
         BL_CODE_1: burst_len = COL_W'(1);
         BL_CODE_2: burst_len = COL_W'(2);
         BL_CODE_4: burst_len = COL_W'(4);
         BL_CODE_8: burst_len = COL_W'(8);
         default: burst_len = '0;
      endcase
   endfunction
   function automatic logic [1:0] read_lat(input logic [2:0] code);
      case (code)
         RL_CODE_3: read_lat = 2'h3;
         default: read_lat = 2'h2;
      endcase
   endfunction
   logic [COL_W-1:0] gen_col;
   sdcm_burst_addr #(.CW(COL_W)) u_addr (
      .start_col  (s_r.bcol),
      .beat       (s_r.beat),
      .bl_code    (s_r.mode[BL_MSB:BL_LSB]),
      .interleave (s_r.mode[BT_BIT]),
      .col        (gen_col)
   );
   logic [DATA_W-1:0] rd_word;
   logic             rb_in_valid;
   logic             rb_in_ready;
   logic             rb_out_valid;
   sdcm_beat_s       rb_out;
   sdcm_skid #(.W(DATA_W + MASK_W)) u_skid (
      .clk       (SYS_CLK),
      .rst       (RST),
      .in_valid  (rb_in_valid),
      .in_ready  (rb_in_ready),
      .in_data   ({rd_word, s_r.mask_d1}),
      .out_valid (rb_out_valid),
      .out_ready (1'b1),
      .out_data  (rb_out)
   );
   // ------------------------------------------------------------
   // command decode and state update
   // ------------------------------------------------------------
   logic live, c_mrs, c_act, c_pre, c_rd, c_wr, c_ref, c_self, c_stop;
   logic single_wr, gate_now, gate_fall, gate_rise, last_beat;
   logic [1:0] rl;
   always_comb begin
      cmd = '{CHIP_SELECT_N, ROW_STROBE_N, COLUMN_STROBE_N, WRITE_STROBE_N,
              CLK_GATE, BANK_SELECT, ADDR};
      s_nxt = s_r;
      // gate pin is asynchronous in low power states; count when stages 2 and 3 agree
      s_nxt.gate_sync = {s_r.gate_sync[1:0], cmd.clk_gate};
      gate_now = (s_r.gate_sync[2] == s_r.gate_sync[1]) ? s_r.gate_sync[1] : s_r.gate_q;
      s_nxt.gate_q = gate_now;
      gate_fall = s_r.gate_q && !gate_now;
      gate_rise = !s_r.gate_q && gate_now;
      live = !cmd.chip_select_n && (s_r.st == ST_IDLE || s_r.st == ST_BURST);
      c_mrs  = live && !cmd.row_strobe_n && !cmd.column_strobe_n && !cmd.write_strobe_n;
      c_act  = live && !cmd.row_strobe_n && cmd.column_strobe_n && cmd.write_strobe_n;
      c_pre  = live && !cmd.row_strobe_n && cmd.column_strobe_n && !cmd.write_strobe_n;
      c_rd   = live && cmd.row_strobe_n && !cmd.column_strobe_n && cmd.write_strobe_n;
      c_wr   = live && cmd.row_strobe_n && !cmd.column_strobe_n && !cmd.write_strobe_n;
      c_stop = live && cmd.row_strobe_n && cmd.column_strobe_n && !cmd.write_strobe_n;
      c_ref  = live && !cmd.row_strobe_n && !cmd.column_strobe_n && cmd.write_strobe_n
               && cmd.clk_gate;
      c_self = live && !cmd.row_strobe_n && !cmd.column_strobe_n && cmd.write_strobe_n
               && !cmd.clk_gate;
      single_wr = (s_r.mode[OP_MSB:OP_LSB] == OP_SINGLE_WR);
      rl = read_lat(s_r.mode[RL_MSB:RL_LSB]);
      last_beat = (s_r.left == COL_W'(1));
      s_nxt.rpulse = 1'b0;
      s_nxt.awr = 1'b0;
      s_nxt.mask_d1 = BYTE_MASK;
      // read valid pipe shifts; tap chosen by latency
      s_nxt.rdv = {s_r.rdv[RL_PIPE-2:0], 1'b0};
      // array word travels with its valid so a longer latency keeps beat and column paired
      s_nxt.rdp = {s_r.rdp[RL_PIPE-3:0], ARR_RDATA};
      // burst beat advance
      if (s_r.st == ST_BURST) begin
         s_nxt.abank = s_r.bbank;
         s_nxt.arow = s_r.row[s_r.bbank];
         s_nxt.acol = gen_col;
         s_nxt.beat = s_r.beat + COL_W'(1);
         if (s_r.bwr) begin
            s_nxt.awr = (BYTE_MASK != '1);
            s_nxt.awdata = DQ_IN;
            s_nxt.awmask = BYTE_MASK;
         end else begin
            s_nxt.rdv[0] = 1'b1;
         end
         // a zero count marks full page, which only a command ends
         if (last_beat) begin
            s_nxt.st = ST_IDLE;
            if (s_r.bap) begin
               s_nxt.open[s_r.bbank] = 1'b0;
            end
         end
         if (s_r.left != '0) begin
            s_nxt.left = s_r.left - COL_W'(1);
         end
      end
      if (c_mrs) begin
         s_nxt.mode = {cmd.bank_select, cmd.addr};
         s_nxt.st = ST_IDLE;
      end else if (c_act) begin
         s_nxt.open[cmd.bank_select] = 1'b1;
         s_nxt.row[cmd.bank_select] = cmd.addr;
      end else if (c_pre) begin
         s_nxt.st = ST_IDLE;
         if (cmd.addr[PRE_ALL_BIT]) begin
            s_nxt.open = '0;
         end else begin
            s_nxt.open[cmd.bank_select] = 1'b0;
         end
      end else if (c_rd || c_wr) begin
         // interrupts the running burst and restarts from the new column
         s_nxt.st = ST_BURST;
         s_nxt.bbank = cmd.bank_select;
         s_nxt.bcol = cmd.addr[COL_W-1:0];
         s_nxt.beat = '0;
         s_nxt.bwr = c_wr;
         s_nxt.bap = cmd.addr[PRE_ALL_BIT];
         s_nxt.left = (c_wr && single_wr) ? COL_W'(1)
                      : burst_len(s_r.mode[BL_MSB:BL_LSB]);
      end else if (c_stop) begin
         s_nxt.st = ST_IDLE;
      end else if (c_ref || c_self) begin
         // internal counter supplies the row; banks end idle
         s_nxt.rcnt = s_r.rcnt + ADDR_W'(1);
         s_nxt.rpulse = 1'b1;
         s_nxt.open = '0;
         s_nxt.st = c_self ? ST_SELF : ST_IDLE;
      end else if (s_r.st == ST_IDLE && gate_fall && s_r.open == '0) begin
         s_nxt.st = ST_PDOWN;
      end
      if ((s_r.st == ST_SELF || s_r.st == ST_PDOWN) && gate_rise) begin
         s_nxt.st = ST_IDLE;
      end
      // read output stage with mask two clocks old
      rb_in_valid = s_r.rdv[rl - 2'h1];
      rd_word = s_r.rdp[rl - 2'h2];
      READ_STALL = !rb_in_ready;
      if (rb_out_valid) begin
         s_nxt.dout = rb_out.data;
         s_nxt.oe = ~rb_out.mask;
      end else begin
         s_nxt.oe = '0;
      end
   end
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         s_r <= '{st: ST_IDLE, mode: MODE_RST, gate_sync: 3'h7, gate_q: 1'b1,
                  default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end
   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign DQ_OUT        = s_r.dout;
   assign DQ_OE         = s_r.oe;
   assign ARR_WR        = s_r.awr;
   assign ARR_BANK      = s_r.abank;
   assign ARR_ROW       = s_r.arow;
   assign ARR_COL       = s_r.acol;
   assign ARR_WDATA     = s_r.awdata;
   assign ARR_WMASK     = s_r.awmask;
   assign MODE_VALUE    = s_r.mode;
   assign BANK_OPEN     = s_r.open;
   assign SELF_REFRESH  = (s_r.st == ST_SELF);
   assign POWER_DOWN    = (s_r.st == ST_PDOWN);
   assign REFRESH_PULSE = s_r.rpulse;
   assign REFRESH_ROW   = s_r.rcnt;
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence mrs_seq;
      !CHIP_SELECT_N && !ROW_STROBE_N && !COLUMN_STROBE_N && !WRITE_STROBE_N
      && (s_r.st == ST_IDLE || s_r.st == ST_BURST);
   endsequence
   a_mode_load: assert property (@(posedge SYS_CLK) disable iff (RST)
      mrs_seq |=> MODE_VALUE == $past({BANK_SELECT, ADDR}))
      else $error("mode not loaded");
   a_deselect_mask: assert property (@(posedge SYS_CLK) disable iff (RST)
      CHIP_SELECT_N && s_r.st == ST_IDLE |=> $stable(MODE_VALUE) && $stable(BANK_OPEN))
      else $error("deselected command acted");
   a_act_open: assert property (@(posedge SYS_CLK) disable iff (RST)
      c_act |=> BANK_OPEN[$past(BANK_SELECT)])
      else $error("activate did not open bank");
   a_pre_all: assert property (@(posedge SYS_CLK) disable iff (RST)
      c_pre && ADDR[PRE_ALL_BIT] |=> BANK_OPEN == '0)
      else $error("precharge all missed");
   a_refresh_cnt: assert property (@(posedge SYS_CLK) disable iff (RST)
      c_ref |=> REFRESH_PULSE && REFRESH_ROW == $past(REFRESH_ROW) + ADDR_W'(1))
      else $error("refresh counter stuck");
   a_self_enter: assert property (@(posedge SYS_CLK) disable iff (RST)
      c_self |=> SELF_REFRESH)
      else $error("self refresh not entered");
   a_write_mask: assert property (@(posedge SYS_CLK) disable iff (RST)
      s_r.st == ST_BURST && s_r.bwr && BYTE_MASK == '1 |=> !ARR_WR)
      else $error("masked write reached array");
   a_burst_four: assert property (@(posedge SYS_CLK) disable iff (RST)
      (c_rd || c_wr) && s_r.mode[BL_MSB:BL_LSB] == BL_CODE_4
      && !(c_wr && single_wr) ##1 (!(c_rd || c_wr || c_pre || c_stop || c_mrs))[*4]
      |=> s_r.st == ST_IDLE)
      else $error("burst of four wrong length");
   a_interleave: assert property (@(posedge SYS_CLK) disable iff (RST)
      s_r.st == ST_BURST && s_r.mode[BT_BIT] && s_r.mode[BL_MSB:BL_LSB] == BL_CODE_8
      |-> gen_col[2:0] == (s_r.bcol[2:0] ^ s_r.beat[2:0]))
      else $error("interleave order wrong");
endmodule // sdcm_core
`default_nettype wire

// [sdcm_ctl_model.sv]
// controller model: power-up sequence and one-cycle commands toward the device
`timescale 1ns/1ps
`default_nettype none
module sdcm_ctl_model import sdcm_pkg::*; #(
   parameter int PAUSE_CYC = 20000
) (
   // clock
   input  wire logic             clk,
   // pins toward the device
   output var sdcm_cmd_s         cmd,
   output var logic [MASK_W-1:0] mask,
   output var logic [DATA_W-1:0] dq
);
   // --------------------------------------------------------------
   // command issue
   // --------------------------------------------------------------
   initial begin
      cmd = {4'hf, 1'b1, 2'h0, 12'h000};
      mask = '1;
      dq = 32'h3c3c3c3c;
   end
   // data lines never hold a stale value between beats
   always @(negedge clk) dq <= ~dq + 32'h1;
   task automatic c(input logic [3:0] k, input logic [1:0] b, input logic [11:0] a,
                    input logic g = 1'b1);
      @(negedge clk);
      {cmd.chip_select_n, cmd.row_strobe_n, cmd.column_strobe_n, cmd.write_strobe_n} = k;
      cmd.bank_select = b;
      cmd.addr = a;
      cmd.clk_gate = g;
      @(negedge clk);
      {cmd.chip_select_n, cmd.row_strobe_n, cmd.column_strobe_n, cmd.write_strobe_n} = 4'h7;
   endtask
   task automatic init(input logic [MODE_W-1:0] m);
      repeat (PAUSE_CYC) @(negedge clk);
      mask = '0;
      c(4'h2, 2'h0, 12'h400);
      repeat (2) begin
         c(4'h1, 2'h0, 12'h000);
         repeat (ROW_CYCLE_CYC) @(negedge clk);
      end
      c(4'h0, m[13:12], m[11:0]);
   endtask
endmodule // sdcm_ctl_model
`default_nettype wire

// [testbench.sv]
// self-checking bench for the sdram command and mode logic
`timescale 1ns/1ps
`default_nettype none
module testbench import sdcm_pkg::*; ();
   localparam logic [3:0] MRS = 4'h0, PRE = 4'h2, ACT = 4'h3, WR = 4'h4, RD = 4'h5;
   logic SYS_CLK, RST, ARR_WR, SELF_REFRESH, POWER_DOWN, REFRESH_PULSE, READ_STALL;
   logic [DATA_W-1:0] DQ_OUT, ARR_RDATA;
   logic [MASK_W-1:0] DQ_OE, ARR_WMASK, mask;
   logic [COL_W-1:0]  ARR_COL;
   logic [MODE_W-1:0] MODE_VALUE;
   logic [NBANK-1:0]  BANK_OPEN;
   logic [ADDR_W-1:0] REFRESH_ROW;
   logic [DATA_W-1:0] dq;
   sdcm_cmd_s         cmd;
   logic [COL_W-1:0]  wq[$];
   logic [MASK_W-1:0] mq[$];
   int errors = 0, compares = 0, refs = 0;
   sdcm_ctl_model ctl (.clk(SYS_CLK), .cmd(cmd), .mask(mask), .dq(dq));
   sdcm_core DUT (
      .SYS_CLK(SYS_CLK), .RST(RST), .CHIP_SELECT_N(cmd.chip_select_n),
      .ROW_STROBE_N(cmd.row_strobe_n), .COLUMN_STROBE_N(cmd.column_strobe_n),
      .WRITE_STROBE_N(cmd.write_strobe_n), .CLK_GATE(cmd.clk_gate),
      .BANK_SELECT(cmd.bank_select), .ADDR(cmd.addr), .BYTE_MASK(mask), .DQ_IN(dq),
      .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .ARR_WR(ARR_WR), .ARR_BANK(), .ARR_ROW(),
      .ARR_COL(ARR_COL), .ARR_WDATA(), .ARR_WMASK(ARR_WMASK), .ARR_RDATA(ARR_RDATA),
      .MODE_VALUE(MODE_VALUE), .BANK_OPEN(BANK_OPEN), .SELF_REFRESH(SELF_REFRESH),
      .POWER_DOWN(POWER_DOWN), .REFRESH_PULSE(REFRESH_PULSE),
      .REFRESH_ROW(REFRESH_ROW), .READ_STALL(READ_STALL));
   // --------------------------------------------------------------
   // array model and monitors
   // --------------------------------------------------------------
   assign ARR_RDATA = {ARR_COL, 24'ha5a5a5};
   always @(posedge SYS_CLK) begin
      if (ARR_WR === 1'b1) begin
         wq.push_back(ARR_COL);
         mq.push_back(ARR_WMASK);
      end
      if (REFRESH_PULSE === 1'b1) refs++;
   end
   initial begin
      SYS_CLK = 1'b0;
      forever #5 SYS_CLK = ~SYS_CLK;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wrap_up();
      if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // expected column of beat k; block size l aligns the wrap
   function automatic logic [7:0] ecol(input logic [7:0] s, input int k, input int l,
                                       input logic il);
      logic [7:0] m;
      m = 8'(l - 1);
      ecol = il ? (s ^ 8'(k)) : ((s & ~m) | ((s + 8'(k)) & m));
   endfunction
   task automatic burst(input logic [2:0] bl, input logic il, input logic sw, input int l);
      logic [13:0] m;
      int n;
      m = {sw ? OP_SINGLE_WR : OP_BURST_WRITE, RL_CODE_2, il, bl};
      ctl.c(PRE, 2'h0, 12'h400);
      ctl.c(MRS, m[13:12], m[11:0]);
      chk(MODE_VALUE, m);
      ctl.c(ACT, 2'h1, 12'h123);
      chk(BANK_OPEN, 4'h2);
      wq.delete();
      mq.delete();
      ctl.c(WR, 2'h1, 12'h005);
      ctl.mask = 4'h9;
      @(negedge SYS_CLK);
      ctl.mask = 4'h0;
      repeat (12) @(negedge SYS_CLK);
      n = sw ? 1 : l;
      chk(32'(wq.size()), 32'(n));
      chk(mq[0], 4'h9);
      if (n > 1) chk(mq[1], 4'h0);
      for (int i = 0; i < n; i++) chk(wq[i], ecol(8'h05, i, l, il));
   endtask
   task automatic rdlat(input logic [2:0] rl, input logic mk, output int t);
      logic [3:0] oe;
      oe = 4'h0;
      ctl.c(PRE, 2'h0, 12'h400);
      ctl.c(MRS, 2'h0, {5'h0, rl, 1'b0, BL_CODE_4});
      ctl.c(ACT, 2'h2, 12'h000);
      ctl.mask = {3'h0, mk};
      ctl.c(RD, 2'h2, 12'h010);
      for (t = 0; t < 20 && DQ_OE === 4'h0; t++) @(negedge SYS_CLK);
      chk(DQ_OUT[31:8], {8'h10, 16'ha5a5});
      repeat (8) begin
         oe = oe | DQ_OE;
         @(negedge SYS_CLK);
      end
      chk(oe, mk ? 4'he : 4'hf);
      ctl.mask = 4'h0;
   endtask
   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial begin
      int t2, t3, j, i;
      RST = 1'b1;
      repeat (20) @(negedge SYS_CLK);
      RST = 1'b0;
      ctl.init({OP_BURST_WRITE, RL_CODE_2, 1'b0, BL_CODE_4});
      chk(32'(refs), 2);
      chk(REFRESH_ROW, 2);
      burst(BL_CODE_1, 1'b0, 1'b0, 1);
      burst(BL_CODE_2, 1'b0, 1'b0, 2);
      burst(BL_CODE_4, 1'b0, 1'b0, 4);
      burst(BL_CODE_8, 1'b0, 1'b0, 8);
      burst(BL_CODE_8, 1'b1, 1'b0, 8);
      burst(BL_CODE_4, 1'b1, 1'b0, 4);
      burst(BL_CODE_4, 1'b0, 1'b1, 4);
      ctl.c(PRE, 2'h0, 12'h400);
      ctl.c(MRS, 2'h0, {5'h0, RL_CODE_2, 1'b0, BL_CODE_PAGE});
      ctl.c(ACT, 2'h1, 12'h000);
      wq.delete();
      ctl.c(WR, 2'h1, 12'h0fe);
      repeat (4) @(negedge SYS_CLK);
      ctl.c(WR, 2'h1, 12'h010);
      repeat (4) @(negedge SYS_CLK);
      j = -1;
      foreach (wq[k]) if (wq[k] === 8'h10 && j < 0) j = k;
      chk(wq[2], 8'h00);
      chk(32'(j > 3), 1);
      chk(wq[j+1], 8'h11);
      rdlat(RL_CODE_2, 1'b0, t2);
      rdlat(RL_CODE_3, 1'b1, t3);
      chk(32'(t3 - t2), 1);
      ctl.c(ACT, 2'h1, 12'h001);
      ctl.c(ACT, 2'h2, 12'h001);
      ctl.c(PRE, 2'h1, 12'h000);
      chk(BANK_OPEN, 4'h4);
      ctl.c(PRE, 2'h0, 12'h400);
      chk(BANK_OPEN, 4'h0);
      ctl.c(4'h8, 2'h0, 12'h3ff);
      ctl.c(4'hb, 2'h3, 12'h001);
      chk({BANK_OPEN, MODE_VALUE}, {4'h0, 7'h0, RL_CODE_3, 1'b0, BL_CODE_4});
      ctl.c(4'h1, 2'h0, 12'h000, 1'b0);
      chk(SELF_REFRESH, 1'b1);
      ctl.c(ACT, 2'h3, 12'h001, 1'b0);
      chk(BANK_OPEN, 4'h0);
      ctl.c(4'h7, 2'h0, 12'h000);
      for (i = 0; i < 8 && SELF_REFRESH !== 1'b0; i++) @(negedge SYS_CLK);
      chk(SELF_REFRESH, 1'b0);
      repeat (ROW_CYCLE_CYC) @(negedge SYS_CLK);
      ctl.c(4'h7, 2'h0, 12'h000, 1'b0);
      for (i = 0; i < 8 && POWER_DOWN !== 1'b1; i++) @(negedge SYS_CLK);
      chk(POWER_DOWN, 1'b1);
      ctl.c(4'h7, 2'h0, 12'h000);
      for (i = 0; i < 8 && POWER_DOWN !== 1'b0; i++) @(negedge SYS_CLK);
      chk(POWER_DOWN, 1'b0);
      chk(READ_STALL, 1'b0);
      wrap_up();
   end
   initial begin
      repeat (60000) @(posedge SYS_CLK);
      errors++;
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
